// *** rtl/eif_filter.sv ***
/*
 * Noise filter for one request line: passes a new level only after it
 * has held for the programmed number of filter ticks.
 * Assumes raw and tick are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module eif_filter #(
	parameter int WIDTH_W = 7
) (
	input wire logic clk,
	input wire logic nrst,
	eif_flt_if.flt fp
);
	logic [WIDTH_W-1:0] cnt_r;
	logic [WIDTH_W-1:0] cnt_nxt;
	logic lvl_r;
	logic lvl_nxt;
	logic [WIDTH_W:0] cnt_inc;

	if (WIDTH_W < 1 || WIDTH_W > 16) begin : g_bad_w
		$error("eif_filter: WIDTH_W out of range");
	end

	assign cnt_inc = {1'b0, cnt_r} + {{WIDTH_W{1'b0}}, 1'b1};

	always_comb begin
		lvl_nxt = lvl_r;
		cnt_nxt = cnt_r;
		if (!fp.on) begin
			// Track the pin while bypassed so enabling causes no glitch
			lvl_nxt = fp.raw;
			cnt_nxt = '0;
		end else if (fp.raw == lvl_r) begin
			cnt_nxt = '0;
		end else if (fp.tick) begin
			// Width zero acts as one tick
			if (cnt_inc >= {1'b0, fp.width}) begin // RL16
				lvl_nxt = fp.raw;
				cnt_nxt = '0;
			end else begin
				cnt_nxt = cnt_inc[WIDTH_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
			lvl_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	assign fp.level = lvl_r;

	chk_flt_hold_width: assert property (@(posedge clk) disable iff (!nrst) // RL16
		($past(fp.on) && $changed(lvl_r)) |->
		($past(fp.tick) && ({1'b0, $past(cnt_r)} + 1 >= {1'b0, $past(fp.width)})))
		else $error("filtered level changed before width elapsed");
endmodule : eif_filter
`default_nettype wire

// *** rtl/eif_flt_if.sv ***
/*
 * Link between the request front end and one noise filter.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface eif_flt_if #(parameter int WIDTH_W = 7);
	logic tick;
	logic on;
	logic [WIDTH_W-1:0] width;
	logic raw;
	logic level;
	modport ctl (output tick, output on, output width, output raw, input level);
	modport flt (input tick, input on, input width, input raw, output level);
endinterface : eif_flt_if
`default_nettype wire

// *** rtl/eif_pkg.sv ***
/*
 * Shared constants of the external request front end: register byte
 * addresses, field layout, reset values and trigger codes.
 * Assumes a 32-bit register port with byte addresses.
 */
package eif_pkg;
	localparam logic [31:0] ADDR_TRIG = 32'h4480_0020;
	localparam logic [31:0] ADDR_FLT_LO = 32'h4480_0024;
	localparam logic [31:0] ADDR_FLT_HI = 32'h4480_0028;
	localparam logic [31:0] ADDR_MASK = 32'h4480_0034;
	localparam logic [31:0] ADDR_PEND = 32'h4480_0038;

	localparam int NSRC = 19;
	localparam int NLOW = 10;
	localparam int NUP = 8;
	localparam int FIRST_UP = 11;
	localparam int NIB_W = 4;
	localparam int CODE_W = 3;
	localparam int FEN_BIT = 3;
	localparam int FLT_BYTE = 8;
	localparam int FLT_W = 7;
	localparam int FCLK_BIT = 7;

	localparam logic [31:0] TRIG_RST = 32'h0000_0000;
	localparam logic [31:0] FLT_RST = 32'h0000_0000;
	localparam logic [18:0] MASK_RST = 19'h7_ffff;
	localparam logic [18:0] PEND_RST = 19'h0_0000;
	localparam logic [18:0] SRC_VALID = 19'h7_fbff;

	localparam logic [2:0] TRIG_LOW = 3'h0;
	localparam logic [2:0] TRIG_HIGH = 3'h1;
	localparam logic [1:0] TRIG_FALL = 2'h1;
	localparam logic [1:0] TRIG_RISE = 2'h2;
	localparam logic [1:0] TRIG_BOTH = 2'h3;
endpackage : eif_pkg

// *** rtl/eif_top.sv ***
/*
 * External request front end: trigger decode and noise filters for
 * sources 11 to 18, pending latch and mask for all 18 sources.
 * Assumes pins and the alternate filter clock pins are synchronous to
 * core_clk; sources 0 to 9 arrive as already detected event pulses.
 */
// Function
// (RL1) Trigger code 000 requests on a low level and 001 on a high level.
// (RL2) Codes 01x, 10x and 11x detect falling, rising and both edges, low bit ignored.
// (RL3) The trigger register holds one nibble per source 11..18, code low, filter enable on top.
// (RL4) A set filter enable routes the source through its filter, a clear one bypasses it.
// (RL5) Only sources 11 to 18 have a programmable noise filter.
// (RL6) A filter clock pick of 0 uses the core clock and 1 the alternate slow clock.
// (RL7) Each filter has a 7-bit width in filter clock cycles just below its clock pick bit.
// (RL8) The low filter register serves sources 11..14 and the high one 15..18, higher source on top.
// (RL9) The alternate clock is chosen by the reference pick pin and alive control bit 0.
// (RL10) A set mask bit blocks its source and a clear one lets it through.
// (RL11) The mask register resets to 0x0007ffff.
// (RL12) Mask bits map to sources 0..9 and 11..18, bit 10 is reserved.
// (RL13) Trigger and both filter registers reset to zero.
// (RL14) Writing ones to the pending register clears those bits only.
// (RL15) The interrupt output is high while any unmasked pending bit is set.
// (RL16) A filtered line passes a new level only after holding for the programmed width.
`timescale 1ns/1ps
`default_nettype none
module eif_top #(
	parameter int NUM_UP = 8,
	parameter int FW = 7
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [7:0] external_request_line,
	input wire logic [9:0] low_event,
	input wire logic external_clock_pin,
	input wire logic crystal_clock_pin,
	input wire logic rtc_clock_pin,
	input wire logic reference_clock_pick_pin,
	input wire logic alive_clock_pick,
	output logic irq_o
);
	if (NUM_UP != eif_pkg::NUP || FW != eif_pkg::FLT_W) begin : g_bad_cfg
		$error("eif_top: register layout fixes NUM_UP and FW");
	end

	logic [31:0] trig_r;
	logic [31:0] trig_nxt;
	logic [63:0] flt_r;
	logic [63:0] flt_nxt;
	logic [18:0] mask_r;
	logic [18:0] mask_nxt;
	logic [18:0] pend_r;
	logic [18:0] pend_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic irq_r;
	logic irq_nxt;
	logic [NUM_UP-1:0] prev_r;
	logic [NUM_UP-1:0] lvl_now;
	logic [NUM_UP-1:0] up_hit;
	logic alt_prev_r;
	logic alt_sel;
	logic alt_tick;
	logic [18:0] set_vec;
	logic [18:0] clr_vec;
	logic wr_pend;

	// Returns whether a source requests service this cycle
	function automatic logic trig_hit(input logic [2:0] code, input logic cur,
		input logic prev);
		logic res;
		res = 1'b0;
		if (code == eif_pkg::TRIG_LOW) begin
			res = !cur; // RL1
		end else if (code == eif_pkg::TRIG_HIGH) begin
			res = cur; // RL1
		end else begin
			unique case (code[2:1])
				eif_pkg::TRIG_FALL: res = prev && !cur; // RL2
				eif_pkg::TRIG_RISE: res = !prev && cur; // RL2
				eif_pkg::TRIG_BOTH: res = prev != cur; // RL2
				default: res = 1'b0;
			endcase
		end
		return res;
	endfunction : trig_hit

	// Alternate filter clock, sampled; rising edge gives one tick
	assign alt_sel = alive_clock_pick ? rtc_clock_pin :
		(reference_clock_pick_pin ? external_clock_pin : crystal_clock_pin); // RL9
	assign alt_tick = alt_sel && !alt_prev_r;

	// Filters exist only for the upper group
	for (genvar k = 0; k < NUM_UP; k++) begin : g_up // RL5
		logic [2:0] code;
		logic fen;
		logic fclk;
		eif_flt_if #(.WIDTH_W(FW)) fi ();

		assign code = trig_r[k*eif_pkg::NIB_W +: eif_pkg::CODE_W]; // RL3
		assign fen = trig_r[k*eif_pkg::NIB_W + eif_pkg::FEN_BIT]; // RL3
		// Low word holds 11..14, high word 15..18
		assign fclk = flt_r[k*eif_pkg::FLT_BYTE + eif_pkg::FCLK_BIT]; // RL8
		assign fi.width = flt_r[k*eif_pkg::FLT_BYTE +: FW]; // RL7
		assign fi.tick = fclk ? alt_tick : 1'b1; // RL6
		assign fi.on = fen;
		assign fi.raw = external_request_line[k];

		eif_filter #(.WIDTH_W(FW)) u_flt (
			.clk(core_clk),
			.nrst(nrst),
			.fp(fi.flt)
		);

		assign lvl_now[k] = fen ? fi.level : external_request_line[k]; // RL4
		assign up_hit[k] = trig_hit(code, lvl_now[k], prev_r[k]);
	end

	assign wr_pend = reg_wr && (reg_addr == eif_pkg::ADDR_PEND);

	always_comb begin
		set_vec = {up_hit, 1'b0, low_event};
		clr_vec = wr_pend ? reg_wdata[18:0] : '0;
		// New events win over a clear in the same cycle
		pend_nxt = ((pend_r & ~clr_vec) | set_vec) & eif_pkg::SRC_VALID; // RL14 RL12
	end

	always_comb begin
		trig_nxt = trig_r;
		flt_nxt = flt_r;
		mask_nxt = mask_r;
		if (reg_wr) begin
			unique case (reg_addr)
				eif_pkg::ADDR_TRIG: trig_nxt = reg_wdata;
				eif_pkg::ADDR_FLT_LO: flt_nxt[31:0] = reg_wdata;
				eif_pkg::ADDR_FLT_HI: flt_nxt[63:32] = reg_wdata;
				// Reserved bit 10 keeps its reset value
				eif_pkg::ADDR_MASK: mask_nxt = (reg_wdata[18:0] & eif_pkg::SRC_VALID) |
					(eif_pkg::MASK_RST & ~eif_pkg::SRC_VALID); // RL12
				default: ;
			endcase
		end
	end

	always_comb begin
		rdata_nxt = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				eif_pkg::ADDR_TRIG: rdata_nxt = trig_r;
				eif_pkg::ADDR_FLT_LO: rdata_nxt = flt_r[31:0];
				eif_pkg::ADDR_FLT_HI: rdata_nxt = flt_r[63:32];
				eif_pkg::ADDR_MASK: rdata_nxt = {13'h0000, mask_r};
				eif_pkg::ADDR_PEND: rdata_nxt = {13'h0000, pend_r};
				default: rdata_nxt = '0;
			endcase
		end
	end

	// Registered so the output is glitch free; lags pending by one cycle
	always_comb begin
		irq_nxt = |(pend_r & ~mask_r); // RL10 RL15
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// Software-visible configuration
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			trig_r <= eif_pkg::TRIG_RST; // RL13
			flt_r <= {eif_pkg::FLT_RST, eif_pkg::FLT_RST}; // RL13
			mask_r <= eif_pkg::MASK_RST; // RL11
		end else begin
			trig_r <= trig_nxt;
			flt_r <= flt_nxt;
			mask_r <= mask_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pend_r <= eif_pkg::PEND_RST;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// History resets low, so a line already high after reset looks like a rising edge
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prev_r <= '0;
			alt_prev_r <= 1'b0;
		end else begin
			prev_r <= lvl_now;
			alt_prev_r <= alt_sel;
		end
	end

	assign reg_rdata = rdata_r;
	assign irq_o = irq_r;

	chk_level_sets_pend: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
		(up_hit != '0) |=> ((pend_r[18:11] & $past(up_hit)) == $past(up_hit)))
		else $error("requesting source did not latch pending");

	chk_fall_edge_pend: assert property (@(posedge core_clk) disable iff (!nrst) // RL2
		(g_up[0].code[2:1] == eif_pkg::TRIG_FALL && prev_r[0] && !lvl_now[0])
		|=> pend_r[eif_pkg::FIRST_UP])
		else $error("falling edge on source 11 missed");

	chk_irq_gate: assert property (@(posedge core_clk) disable iff (!nrst) // RL15
		((pend_r & ~mask_r) != '0) |=> irq_o ##0 $past(irq_nxt))
		else $error("unmasked pending did not raise interrupt");

	chk_masked_quiet: assert property (@(posedge core_clk) disable iff (!nrst) // RL10
		((pend_r & ~mask_r) == '0) |=> !irq_o)
		else $error("interrupt raised with all pending masked");

	chk_mask_reset: assert property (@(posedge core_clk) // RL11
		$rose(nrst) |-> (mask_r == eif_pkg::MASK_RST))
		else $error("mask not at reset value");

	chk_cfg_reset: assert property (@(posedge core_clk) // RL13
		$rose(nrst) |-> (trig_r == '0 && flt_r == '0))
		else $error("trigger or filter register not zero after reset");

	chk_clear_ones: assert property (@(posedge core_clk) disable iff (!nrst) // RL14
		wr_pend |=> ((pend_r & $past(reg_wdata[18:0] & ~set_vec)) == '0))
		else $error("pending bit written with one not cleared");

	chk_keep_zeros: assert property (@(posedge core_clk) disable iff (!nrst) // RL14
		wr_pend |=> ((pend_r & $past(pend_r & ~reg_wdata[18:0])) ==
		$past(pend_r & ~reg_wdata[18:0])))
		else $error("pending bit written with zero changed");

	chk_bit10_reserved: assert property (@(posedge core_clk) disable iff (!nrst) // RL12
		!pend_r[10] && mask_r[10])
		else $error("reserved bit 10 disturbed");

	// Source 11 stands in for the whole upper group
	chk_low_level_pend: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
		(g_up[0].code == eif_pkg::TRIG_LOW && !lvl_now[0]) |=> pend_r[eif_pkg::FIRST_UP])
		else $error("low level on source 11 missed");

	chk_high_level_pend: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
		(g_up[0].code == eif_pkg::TRIG_HIGH && lvl_now[0]) |=> pend_r[eif_pkg::FIRST_UP])
		else $error("high level on source 11 missed");

	chk_rise_edge_pend: assert property (@(posedge core_clk) disable iff (!nrst) // RL2
		(g_up[0].code[2:1] == eif_pkg::TRIG_RISE && !prev_r[0] && lvl_now[0])
		|=> pend_r[eif_pkg::FIRST_UP])
		else $error("rising edge on source 11 missed");

	chk_no_false_edge: assert property (@(posedge core_clk) disable iff (!nrst) // RL2
		(g_up[0].code[2:1] != '0 && prev_r[0] == lvl_now[0]) |-> !up_hit[0])
		else $error("edge mode fired on a steady line");

	chk_trig_write: assert property (@(posedge core_clk) disable iff (!nrst) // RL3
		(reg_wr && reg_addr == eif_pkg::ADDR_TRIG) |=> (trig_r == $past(reg_wdata)))
		else $error("trigger register write lost");

	chk_flt_write: assert property (@(posedge core_clk) disable iff (!nrst) // RL8
		(reg_wr && reg_addr == eif_pkg::ADDR_FLT_HI) |=>
		(flt_r[63:32] == $past(reg_wdata) && flt_r[31:0] == $past(flt_r[31:0])))
		else $error("high filter register write misplaced");

	chk_mask_write: assert property (@(posedge core_clk) disable iff (!nrst) // RL12
		(reg_wr && reg_addr == eif_pkg::ADDR_MASK) |=>
		(mask_r[9:0] == $past(reg_wdata[9:0]) && mask_r[18:11] == $past(reg_wdata[18:11])))
		else $error("mask register write lost");

	chk_mask_readback: assert property (@(posedge core_clk) disable iff (!nrst) // RL12
		(reg_rd && reg_addr == eif_pkg::ADDR_MASK) |=> (reg_rdata[10] && reg_rdata[31:19] == '0))
		else $error("mask readback reserved bits wrong");

	chk_pend_readback: assert property (@(posedge core_clk) disable iff (!nrst) // RL12
		(reg_rd && reg_addr == eif_pkg::ADDR_PEND) |=>
		(!reg_rdata[10] && reg_rdata[18:0] == $past(pend_r)))
		else $error("pending readback wrong");

	chk_rdata_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		!reg_rd |=> (reg_rdata == '0))
		else $error("read data stands without a read");
endmodule : eif_top
`default_nettype wire

// *** test/eif_pins.sv ***
/* Board side of the request pins: line levels and the slow alternate clocks.
   Assumes the bench sets lvl right after core_clk edges. */
`timescale 1ns/1ps
`default_nettype none
module eif_pins (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] lvl,
	output logic [7:0] external_request_line,
	output logic external_clock_pin,
	output logic crystal_clock_pin,
	output logic rtc_clock_pin
);
	logic [4:0] div_r;
	// Slow clocks as divided counts, so filter ticks are spaced apart
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			div_r <= 5'h00;
		else
			div_r <= div_r + 5'h01;
	end
	assign external_request_line = lvl;
	assign external_clock_pin = div_r[2];
	assign crystal_clock_pin = div_r[3];
	assign rtc_clock_pin = div_r[4];
endmodule : eif_pins
`default_nettype wire

// *** test/tb_top.sv ***
/* Register-level bench of the request front end.
   Assumes the pin model drives the lines; registers are reached by strobes. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] reg_addr = 32'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [7:0] lvl = 8'h00;
	logic [7:0] lines;
	logic [9:0] low_event = 10'h000;
	logic ext_clk, xtal_clk, rtc_clk, irq_o, s, e;
	logic ref_pick = 1'b0;
	logic alive_pick = 1'b0;
	logic [2:0] c;
	logic [31:0] regs [3];
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	always #4 core_clk = ~core_clk;

	eif_pins u_eif_pins (.core_clk(core_clk), .nrst(nrst), .lvl(lvl),
		.external_request_line(lines), .external_clock_pin(ext_clk),
		.crystal_clock_pin(xtal_clk), .rtc_clock_pin(rtc_clk));
	eif_top u_eif_top (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.external_request_line(lines), .low_event(low_event),
		.external_clock_pin(ext_clk), .crystal_clock_pin(xtal_clk),
		.rtc_clock_pin(rtc_clk), .reference_clock_pick_pin(ref_pick),
		.alive_clock_pick(alive_pick), .irq_o(irq_o));

	task end_of_test;
		$display("Checks %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	always @(posedge core_clk) begin
		cycles++;
		// Whole run needs well under a tenth of this
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task rdm(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata & m, exp);
	endtask : rdm

	initial begin
		regs = '{eif_pkg::ADDR_TRIG, eif_pkg::ADDR_FLT_LO, eif_pkg::ADDR_FLT_HI};
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rdm(regs[i], ALL, 32'h0);
			wr(regs[i], 32'ha5a5_c3c3);
			rdm(regs[i], ALL, 32'ha5a5_c3c3);
			wr(regs[i], 32'h0);
		end
		rdm(eif_pkg::ADDR_MASK, ALL, 32'h0007_ffff);
		rdm(32'h4480_0030, ALL, 32'h0);
		wr(eif_pkg::ADDR_MASK, 32'h0);
		rdm(eif_pkg::ADDR_MASK, ALL, 32'h0000_0400);
		for (int k = 0; k < 16; k++) begin
			c = k[3:1];
			s = k[0];
			lvl[0] <= s;
			wr(eif_pkg::ADDR_TRIG, {29'h0, c});
			cyc(2);
			wr(eif_pkg::ADDR_PEND, ALL);
			lvl[0] <= ~s;
			cyc(2);
			e = c[2:1] == 2'h0 || c[2:1] == 2'h3 || (c[2:1] == 2'h1) == s;
			rdm(eif_pkg::ADDR_PEND, 32'h800, {20'h0, e, 11'h0});
			wr(eif_pkg::ADDR_PEND, ALL);
			cyc(2);
			e = c[2:1] == 2'h0 && c[0] == !s;
			rdm(eif_pkg::ADDR_PEND, 32'h800, {20'h0, e, 11'h0});
		end
		wr(eif_pkg::ADDR_TRIG, 32'h4);
		wr(eif_pkg::ADDR_PEND, ALL);
		wr(eif_pkg::ADDR_MASK, 32'h0007_ffef);
		low_event <= 10'h018;
		@(posedge core_clk);
		low_event <= 10'h000;
		cyc(2);
		chk({31'h0, irq_o}, 32'h1);
		wr(eif_pkg::ADDR_PEND, 32'h10);
		cyc(2);
		chk({31'h0, irq_o}, 32'h0);
		// Sources 12 to 18 sit at low-level code with their lines low
		rdm(eif_pkg::ADDR_PEND, ALL, 32'h0007_f008);
		wr(eif_pkg::ADDR_TRIG, 32'hc0);
		wr(eif_pkg::ADDR_FLT_LO, 32'h500);
		cyc(10);
		wr(eif_pkg::ADDR_PEND, ALL);
		lvl[1] <= 1'b1;
		repeat (3) @(posedge core_clk);
		lvl[1] <= 1'b0;
		cyc(12);
		rdm(eif_pkg::ADDR_PEND, 32'h1000, 32'h0);
		lvl[1] <= 1'b1;
		cyc(12);
		rdm(eif_pkg::ADDR_PEND, 32'h1000, 32'h1000);
		ref_pick <= 1'b1;
		wr(eif_pkg::ADDR_TRIG, 32'h000c_0000);
		wr(eif_pkg::ADDR_FLT_HI, 32'h83);
		cyc(40);
		wr(eif_pkg::ADDR_PEND, ALL);
		lvl[4] <= 1'b1;
		cyc(6);
		rdm(eif_pkg::ADDR_PEND, 32'h8000, 32'h0);
		// Read between the third external tick and the earliest third crystal tick
		cyc(20);
		rdm(eif_pkg::ADDR_PEND, 32'h8000, 32'h8000);
		// Slowest alternate clock: after the crystal would be done, before it can be
		alive_pick <= 1'b1;
		wr(eif_pkg::ADDR_TRIG, 32'h000e_0000);
		wr(eif_pkg::ADDR_PEND, ALL);
		lvl[4] <= 1'b0;
		cyc(50);
		rdm(eif_pkg::ADDR_PEND, 32'h8000, 32'h0);
		cyc(50);
		rdm(eif_pkg::ADDR_PEND, 32'h8000, 32'h8000);
		// Reset in mid-run must clear irq and restore the trigger, high filter and mask registers
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq_o}, 32'h0);
		nrst <= 1'b1;
		rdm(eif_pkg::ADDR_TRIG, ALL, 32'h0);
		rdm(eif_pkg::ADDR_FLT_HI, ALL, 32'h0);
		rdm(eif_pkg::ADDR_MASK, ALL, 32'h0007_ffff);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
